// ==== hdl/icc_capture.sv ====
// control register, edge detection and capture logic of one channel
// ----------------------------------------------------------------------
// What this block does
// - idle stop bit halts channel in idle
// - time base select picks the capture clock
// - interrupt after one to four captures
// - interrupt count unused in modes 001, 111
// - overflow flag set when buffer overflows
// - not empty flag shows unread values
// - mode 111 is rising edge wake pin
// - mode 101 captures every 16th rise
// - mode 100 captures every 4th rise
// - mode 011 captures every rising edge
// - mode 010 captures every falling edge
// - mode 001 captures every edge
// - modes 110 and 000 make no captures
// - unimplemented bits read zero, ignore writes
// - reset clears every control and status bit
// ----------------------------------------------------------------------
//
// The register offsets and the address-and-strobe port were decided locally.
`default_nettype none
`include "icc_params.svh"
module icc_capture #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `ICC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  // power state of the cpu
  input wire logic cpu_idle_in,
  input wire logic cpu_sleep_in,
  // capture pin
  input wire logic capture_channel_in,
  // time bases and their count enables
  input wire logic [WIDTH-1:0] timer1_value_in,
  input wire logic [WIDTH-1:0] timer2_value_in,
  input wire logic [WIDTH-1:0] timer3_value_in,
  input wire logic [WIDTH-1:0] timer4_value_in,
  input wire logic [WIDTH-1:0] timer5_value_in,
  input wire logic [WIDTH-1:0] peripheral_clock_value_in,
  input wire logic timer1_clock_in,
  input wire logic timer2_clock_in,
  input wire logic timer3_clock_in,
  input wire logic timer4_clock_in,
  input wire logic timer5_clock_in,
  // events
  output logic capture_irq_out,
  output logic wake_irq_out
);
  // --------------------------------------------------------------------
  // parameter checks
  // --------------------------------------------------------------------
  // refused at elaboration: captured values must fit the 16 bit port
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("icc_capture width must be 1 to 16");
  end

  // --------------------------------------------------------------------
  // control register fields
  // --------------------------------------------------------------------
  logic idle_stop_control_r; // halt in idle
  logic [2:0] time_base_select_r; // capture clock choice
  logic [1:0] captures_per_interrupt_r; // captures per interrupt minus 1
  logic [2:0] capture_mode_select_r; // edge pattern
  logic buffer_overflow_flag_r; // sticky overflow
  logic [1:0] cpi_count_r; // captures since last interrupt
  logic [3:0] pre_count_r; // rising edge prescaler
  logic [WIDTH-1:0] sel_value; // selected time base value
  logic sel_tick; // selected clock enable
  logic capture_event; // a capture happens this cycle
  logic capture_raw; // qualifying edge before state gating
  logic rise_edge; // synchronised rising edge
  logic fall_edge; // synchronised falling edge
  logic pin_s1_r; // first synchroniser stage
  logic pin_s2_r; // second synchroniser stage
  logic pin_s3_r; // previous synchronised level
  logic ctrl_wr; // write to control register
  logic data_rd; // read of capture data
  logic cpi_used; // interrupt count applies
  icc_pkg::icc_state_type state; // channel activity

  icc_fifo_if #(.WIDTH(WIDTH)) fifo ();

  icc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .fifo(fifo)
  );

  assign ctrl_wr = reg_write_in && (reg_addr_in == `ICC_OFS_CONTROL_ONE);
  assign data_rd = reg_read_in && (reg_addr_in == `ICC_OFS_CAPTURE_DATA);

  // --------------------------------------------------------------------
  // control register
  // --------------------------------------------------------------------
  // writable fields; reserved bits are never stored
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      idle_stop_control_r <= 1'b0;
      time_base_select_r <= `ICC_TSEL_T3;
      captures_per_interrupt_r <= 2'h0;
      capture_mode_select_r <= `ICC_MODE_OFF;
    end else if (ctrl_wr) begin
      idle_stop_control_r <= reg_wdata_in[`ICC_BIT_IDLE_STOP];
      time_base_select_r <= reg_wdata_in[`ICC_TSEL_HI:`ICC_TSEL_LO];
      captures_per_interrupt_r <= reg_wdata_in[`ICC_CPI_HI:`ICC_CPI_LO];
      capture_mode_select_r <= reg_wdata_in[`ICC_MODE_HI:`ICC_MODE_LO];
    end
  end

  // --------------------------------------------------------------------
  // channel activity
  // --------------------------------------------------------------------
  // wake mode ignores idle stop; sleep halts every capture mode
  always_comb begin
    if (capture_mode_select_r == `ICC_MODE_WAKE)
      state = icc_pkg::icc_wake_only;
    else if (cpu_sleep_in || (cpu_idle_in && idle_stop_control_r))
      state = icc_pkg::icc_halt;
    else
      state = icc_pkg::icc_run;
  end

  // --------------------------------------------------------------------
  // time base selection
  // --------------------------------------------------------------------
  // reserved codes give no clock, so nothing is sampled on them
  always_comb begin
    case (time_base_select_r)
      `ICC_TSEL_PCLK: begin
        sel_value = peripheral_clock_value_in;
        sel_tick = 1'b1;
      end
      `ICC_TSEL_T1: begin
        sel_value = timer1_value_in;
        sel_tick = timer1_clock_in;
      end
      `ICC_TSEL_T5: begin
        sel_value = timer5_value_in;
        sel_tick = timer5_clock_in;
      end
      `ICC_TSEL_T4: begin
        sel_value = timer4_value_in;
        sel_tick = timer4_clock_in;
      end
      `ICC_TSEL_T2: begin
        sel_value = timer2_value_in;
        sel_tick = timer2_clock_in;
      end
      `ICC_TSEL_T3: begin
        sel_value = timer3_value_in;
        sel_tick = timer3_clock_in;
      end
      default: begin
        sel_value = '0;
        sel_tick = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // pin synchroniser and edge detect
  // --------------------------------------------------------------------
  // two stages, then a history stage for edge detection; the edge is
  // only looked at on a channel clock tick so each is counted once
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      pin_s1_r <= capture_channel_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // history advances on the channel clock, or every cycle in wake mode, so no edge is lost
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in)
      pin_s3_r <= 1'b0;
    else if (sel_tick || state == icc_pkg::icc_wake_only)
      pin_s3_r <= pin_s2_r;
  end

  assign rise_edge = pin_s2_r && !pin_s3_r;
  assign fall_edge = !pin_s2_r && pin_s3_r;

  // --------------------------------------------------------------------
  // capture qualification
  // --------------------------------------------------------------------
  always_comb begin
    case (capture_mode_select_r)
      `ICC_MODE_BOTH: capture_raw = rise_edge || fall_edge;
      `ICC_MODE_FALL: capture_raw = fall_edge;
      `ICC_MODE_RISE: capture_raw = rise_edge;
      `ICC_MODE_RISE4:
        capture_raw = rise_edge && (pre_count_r[1:0] == 2'h3);
      `ICC_MODE_RISE16:
        capture_raw = rise_edge && (pre_count_r == `ICC_PRESCALE_16);
      default: capture_raw = 1'b0;
    endcase
  end

  assign capture_event = capture_raw && sel_tick
                         && (state == icc_pkg::icc_run);

  // prescaler counts rising edges; any control write restarts it
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || ctrl_wr)
      pre_count_r <= 4'h0;
    else if (rise_edge && sel_tick && state == icc_pkg::icc_run)
      pre_count_r <= pre_count_r + 4'h1;
  end

  // wake pin: rising edge only, all other fields ignored
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in)
      wake_irq_out <= 1'b0;
    else
      wake_irq_out <= (state == icc_pkg::icc_wake_only) && rise_edge
                      && (cpu_sleep_in || cpu_idle_in);
  end

  // --------------------------------------------------------------------
  // buffer and flags
  // --------------------------------------------------------------------
  assign fifo.push = capture_event;
  assign fifo.wdata = sel_value;
  assign fifo.pop = data_rd;
  // turning the channel off discards stale captures
  assign fifo.flush = ctrl_wr
    && (reg_wdata_in[`ICC_MODE_HI:`ICC_MODE_LO] == `ICC_MODE_OFF);

  // overflow is set by hardware, cleared by hardware once drained
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in)
      buffer_overflow_flag_r <= 1'b0;
    else if (capture_event && fifo.full)
      buffer_overflow_flag_r <= 1'b1;
    else if (fifo.empty || fifo.flush)
      buffer_overflow_flag_r <= 1'b0;
  end

  // --------------------------------------------------------------------
  // captures per interrupt
  // --------------------------------------------------------------------
  assign cpi_used = (capture_mode_select_r != `ICC_MODE_BOTH);

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || ctrl_wr) begin
      cpi_count_r <= 2'h0;
      capture_irq_out <= 1'b0;
    end else begin
      capture_irq_out <= 1'b0;
      if (capture_event) begin
        if (!cpi_used || cpi_count_r == captures_per_interrupt_r) begin
          cpi_count_r <= 2'h0;
          capture_irq_out <= 1'b1;
        end else begin
          cpi_count_r <= cpi_count_r + 2'h1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------
  // unimplemented bits read zero; unmapped offsets read zero
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in)
      reg_rdata_out <= 16'h0000;
    else if (reg_read_in) begin
      case (reg_addr_in)
        `ICC_OFS_CONTROL_ONE: begin
          reg_rdata_out <= 16'h0000;
          reg_rdata_out[`ICC_BIT_IDLE_STOP] <= idle_stop_control_r;
          reg_rdata_out[`ICC_TSEL_HI:`ICC_TSEL_LO] <= time_base_select_r;
          reg_rdata_out[`ICC_CPI_HI:`ICC_CPI_LO] <= captures_per_interrupt_r;
          reg_rdata_out[`ICC_BIT_OVERFLOW] <= buffer_overflow_flag_r;
          reg_rdata_out[`ICC_BIT_NOT_EMPTY] <= !fifo.empty;
          reg_rdata_out[`ICC_MODE_HI:`ICC_MODE_LO] <= capture_mode_select_r;
        end
        `ICC_OFS_CAPTURE_DATA:
          reg_rdata_out <= fifo.empty ? 16'h0000 : 16'(fifo.rdata);
        `ICC_OFS_STATUS:
          reg_rdata_out <= {14'h0000, buffer_overflow_flag_r, !fifo.empty};
        default: reg_rdata_out <= 16'h0000;
      endcase
    end else
      reg_rdata_out <= 16'h0000;
  end
endmodule
`default_nettype wire

// ==== hdl/icc_params.svh ====
// offsets, field positions, reset values and depths of the capture block
`ifndef ICC_PARAMS_SVH
`define ICC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define ICC_OFS_CONTROL_ONE 4'h0
`define ICC_OFS_CAPTURE_DATA 4'h1
`define ICC_OFS_STATUS 4'h2

// ----------------------------------------------------------------------
// field positions in capture_control_one
// ----------------------------------------------------------------------
`define ICC_BIT_IDLE_STOP 13
`define ICC_TSEL_HI 12
`define ICC_TSEL_LO 10
`define ICC_CPI_HI 6
`define ICC_CPI_LO 5
`define ICC_BIT_OVERFLOW 4
`define ICC_BIT_NOT_EMPTY 3
`define ICC_MODE_HI 2
`define ICC_MODE_LO 0
`define ICC_CTRL_WMASK 16'h3c67
`define ICC_CTRL_RESET 16'h0000

// ----------------------------------------------------------------------
// codes of the mode and time-base fields
// ----------------------------------------------------------------------
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_BOTH 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_RISE4 3'h4
`define ICC_MODE_RISE16 3'h5
`define ICC_MODE_UNUSED 3'h6
`define ICC_MODE_WAKE 3'h7
`define ICC_TSEL_T3 3'h0
`define ICC_TSEL_T2 3'h1
`define ICC_TSEL_T4 3'h2
`define ICC_TSEL_T5 3'h3
`define ICC_TSEL_T1 3'h4
`define ICC_TSEL_PCLK 3'h7

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define ICC_FIFO_DEPTH 4
`define ICC_PRESCALE_4 4'h3
`define ICC_PRESCALE_16 4'hf

`endif

// ==== hdl/icc_pkg.sv ====
// types shared by the capture block files
`default_nettype none
package icc_pkg;
  // channel activity as seen by the edge logic
  typedef enum logic [1:0] {
    icc_run,
    icc_halt,
    icc_wake_only
  } icc_state_type;
endpackage
`default_nettype wire

// ==== hdl/icc_fifo_if.sv ====
// carrier between the capture control and its value buffer
`default_nettype none
interface icc_fifo_if #(parameter int WIDTH = 16);
  logic push; // store one captured value
  logic pop; // drop the oldest value
  logic [WIDTH-1:0] wdata; // value to store
  logic [WIDTH-1:0] rdata; // oldest value
  logic full; // no room left
  logic empty; // nothing stored
  logic flush; // discard all entries
  modport ctrl (output push, output pop, output wdata, output flush,
                input rdata, input full, input empty);
  modport buf_side (input push, input pop, input wdata, input flush,
                    output rdata, output full, output empty);
endinterface
`default_nettype wire

// ==== hdl/icc_fifo.sv ====
// small first-in first-out store for captured time-base values
`default_nettype none
`include "icc_params.svh"
module icc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `ICC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // control side
  icc_fifo_if.buf_side fifo
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  // refused at elaboration: the pointers only wrap cleanly on a power of 2
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("icc_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH]; // stored values
  logic [AW-1:0] wptr_r; // next slot to write
  logic [AW-1:0] rptr_r; // oldest slot
  logic [AW:0] count_r; // number of entries
  logic do_push; // accepted store
  logic do_pop; // accepted removal

  // a push into a full store is dropped; the caller flags overflow
  assign do_push = fifo.push && (count_r != (AW+1)'(DEPTH));
  assign do_pop = fifo.pop && (count_r != '0);
  assign fifo.full = (count_r == (AW+1)'(DEPTH));
  assign fifo.empty = (count_r == '0);
  assign fifo.rdata = mem_r[rptr_r];

  // entry write, no reset needed on data
  always_ff @(posedge ref_clk_in) begin
    if (do_push)
      mem_r[wptr_r] <= fifo.wdata;
  end

  // pointers and occupancy
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in || fifo.flush) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push)
        wptr_r <= wptr_r + AW'(1);
      if (do_pop)
        rptr_r <= rptr_r + AW'(1);
      if (do_push && !do_pop)
        count_r <= count_r + (AW+1)'(1);
      else if (do_pop && !do_push)
        count_r <= count_r - (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ==== tb/icc_pin_model.sv ====
// model of the capture pin and the time bases around the channel
`default_nettype none
module icc_pin_model (
  // clock
  input wire logic ref_clk_in,
  // pin, time-base values by select code, count ticks
  output logic pin_out,
  output logic [7:0][15:0] tval_out,
  output logic [4:0] tick_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 35271; // fixed start so every run repeats
  // quiet pin, counting time bases
  initial begin
    pin_out = 1'b0;
    tval_out = '0;
    tick_out = 5'h1f;
  end
  // new values only while the pin is quiet, so a capture is unambiguous
  task automatic shuffle();
    @(posedge ref_clk_in);
    for (int i = 0; i < 8; i++) tval_out[i] <= 16'($random(seed));
  endtask
  // pin changes just after an edge
  task automatic drive_pin(input logic v);
    @(posedge ref_clk_in);
    pin_out <= v;
  endtask
  // stop or restart the timer ticks
  task automatic set_ticks(input logic [4:0] v);
    @(posedge ref_clk_in);
    tick_out <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb/icc_capture_sva.sv ====
// port assertions of the input capture channel
`default_nettype none
module icc_capture_sva (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  // power state and events
  input wire logic cpu_idle_in,
  input wire logic cpu_sleep_in,
  input wire logic capture_irq_out,
  input wire logic wake_irq_out
);
  logic [15:0] ctrl_r; // shadow of writable control bits
  logic [2:0] mode_d; // mode in the cycle a capture was taken
  // shadow follows control writes only
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) ctrl_r <= 16'h0000;
    else if (reg_write_in && reg_addr_in == 4'h0)
      ctrl_r <= reg_wdata_in & 16'h3c67;
  end
  // irq lags the capture by one cycle, so lag the mode too
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) mode_d <= 3'h0;
    else mode_d <= ctrl_r[2:0];
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  a_off_quiet: assert property (
    (ctrl_r[2:0] inside {3'h0, 3'h6}) && (mode_d inside {3'h0, 3'h6})
    |-> !capture_irq_out) else $error("capture irq while off");
  a_wake_mode: assert property (
    wake_irq_out |-> mode_d == 3'h7) else $error("wake irq outside mode");
  a_wake_power: assert property (
    wake_irq_out |-> $past(cpu_sleep_in) || $past(cpu_idle_in))
    else $error("wake irq while running");
  a_halt_quiet: assert property (
    ($past(cpu_sleep_in) || ($past(cpu_idle_in) && $past(ctrl_r[13])))
    && mode_d != 3'h7 |-> !capture_irq_out)
    else $error("capture irq while halted");
  a_tsel_reserved: assert property (
    ($past(ctrl_r[12:10]) inside {3'h5, 3'h6}) && mode_d != 3'h7
    |-> !capture_irq_out) else $error("capture on reserved time base");
  a_ctrl_unused: assert property (
    reg_read_in && reg_addr_in == 4'h0
    |=> (reg_rdata_out & 16'hc380) == 16'h0000)
    else $error("unimplemented bits not zero");
  a_ctrl_back: assert property (
    reg_read_in && reg_addr_in == 4'h0
    |=> (reg_rdata_out & 16'h3c67) == $past(ctrl_r))
    else $error("control readback wrong");
  a_unmapped_zero: assert property (
    reg_read_in && reg_addr_in > 4'h2 |=> reg_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_ovf_not_empty: assert property (
    reg_read_in && reg_addr_in == 4'h2
    |=> !reg_rdata_out[1] || reg_rdata_out[0])
    else $error("overflow with empty buffer");
endmodule
bind icc_capture icc_capture_sva u_sva (.ref_clk_in, .nrst_in,
  .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
  .reg_rdata_out, .cpu_idle_in, .cpu_sleep_in, .capture_irq_out,
  .wake_irq_out);
`default_nettype wire

// ==== tb/input_capture_control_tb.sv ====
// self-checking bench of the input capture channel
`default_nettype none
module input_capture_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // stimulus, design outputs, reference model
  // ----
  logic clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic idle = 1'b0, sleep = 1'b0, ticks_on = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic pin, cap_irq, wake_irq;
  logic [7:0][15:0] tv;
  logic [4:0] tick;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  int irq_cnt = 0, wake_cnt = 0, irq_exp = 0, wake_exp = 0;
  logic [15:0] q[$]; // values the buffer should hold
  logic [2:0] mode_m = 3'h0, tsel_m = 3'h0;
  logic [1:0] ici_m = 2'h0;
  logic sidl_m = 1'b0, ovf_m = 1'b0;
  int pre_cnt = 0, cap_cnt = 0;
  logic [2:0] modes [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
  always #2.5 clk = ~clk;
  icc_capture DUT (.ref_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en),
    .reg_rdata_out(rdata), .cpu_idle_in(idle), .cpu_sleep_in(sleep),
    .capture_channel_in(pin), .timer1_value_in(tv[4]),
    .timer2_value_in(tv[1]), .timer3_value_in(tv[0]),
    .timer4_value_in(tv[2]), .timer5_value_in(tv[3]),
    .peripheral_clock_value_in(tv[7]), .timer1_clock_in(tick[0]),
    .timer2_clock_in(tick[1]), .timer3_clock_in(tick[2]),
    .timer4_clock_in(tick[3]), .timer5_clock_in(tick[4]),
    .capture_irq_out(cap_irq), .wake_irq_out(wake_irq));
  icc_pin_model u_pin (.ref_clk_in(clk), .pin_out(pin), .tval_out(tv),
    .tick_out(tick));
  // pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (cap_irq === 1'b1) irq_cnt++;
    if (wake_irq === 1'b1) wake_cnt++;
    if (cycles == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] cw(input logic s, input logic [2:0] t,
                                     input logic [1:0] c, input logic [2:0] m);
    return {2'b00, s, t, 3'b000, c, 2'b00, m};
  endfunction
  // a control write restarts prescaler and interrupt counting
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (a == 4'h0) begin
      {sidl_m, tsel_m, ici_m, mode_m} = {d[13:10], d[6:5], d[2:0]};
      {pre_cnt, cap_cnt, irq_cnt, irq_exp, wake_cnt, wake_exp} = '0;
      if (mode_m == 3'h0) q.delete();
    end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic pwr(input logic i, input logic s);
    @(posedge clk);
    idle <= i;
    sleep <= s;
  endtask
  // reference model of one pin edge
  task automatic on_edge(input logic rise);
    logic hit;
    hit = 1'b0;
    if (mode_m == 3'h7) begin
      if (rise && (sleep || idle)) wake_exp++;
      return;
    end
    if (sleep || (idle && sidl_m)) return;
    if (tsel_m inside {3'h5, 3'h6} || (!ticks_on && tsel_m != 3'h7)) return;
    case (mode_m)
      3'h1: hit = 1'b1;
      3'h2: hit = !rise;
      3'h3: hit = rise;
      3'h4, 3'h5: if (rise) begin
        pre_cnt++;
        hit = (pre_cnt == ((mode_m == 3'h4) ? 4 : 16));
        if (hit) pre_cnt = 0;
      end
      default: hit = 1'b0;
    endcase
    if (!hit) return;
    if (q.size() < 4) q.push_back(tv[tsel_m]);
    else ovf_m = 1'b1;
    cap_cnt++;
    if (mode_m == 3'h1 || cap_cnt == int'(ici_m) + 1) begin
      irq_exp++;
      cap_cnt = 0;
    end
  endtask
  task automatic pulse();
    u_pin.shuffle();
    u_pin.drive_pin(1'b1);
    repeat (6) @(posedge clk);
    on_edge(1'b1);
    u_pin.drive_pin(1'b0);
    repeat (6) @(posedge clk);
    on_edge(1'b0);
  endtask
  // empty the buffer and compare everything seen so far
  task automatic drain();
    rd(4'h2, {14'h0, ovf_m, q.size() != 0});
    while (q.size() != 0) rd(4'h1, q.pop_front());
    ovf_m = 1'b0;
    rd(4'h2, 16'h0000);
    chk(16'(irq_cnt), 16'(irq_exp));
    chk(16'(wake_cnt), 16'(wake_exp));
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h2, 16'h0000);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h3c67);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, cw(1'b0, 3'h7, 2'(i + 3), modes[i]));
      repeat (16) begin
        pulse();
        drain();
      end
    end
    $display("test modes done");
    for (int t = 0; t < 8; t++) begin
      wr(4'h0, cw(1'b0, 3'(t), 2'h0, 3'h3));
      pulse();
      drain();
    end
    u_pin.set_ticks(5'h00);
    ticks_on = 1'b0;
    wr(4'h0, cw(1'b0, 3'h1, 2'h0, 3'h3));
    pulse();
    drain();
    u_pin.set_ticks(5'h1f);
    ticks_on = 1'b1;
    $display("test time bases done");
    wr(4'h0, cw(1'b0, 3'h7, 2'h3, 3'h3));
    repeat (5) pulse();
    drain();
    $display("test overflow done");
    wr(4'h0, cw(1'b1, 3'h7, 2'h0, 3'h3));
    pwr(1'b1, 1'b0);
    pulse();
    drain();
    wr(4'h0, cw(1'b0, 3'h7, 2'h0, 3'h3));
    pulse();
    drain();
    pwr(1'b0, 1'b1);
    pulse();
    drain();
    wr(4'h0, cw(1'b1, 3'h5, 2'h1, 3'h7));
    repeat (3) pulse();
    drain();
    pwr(1'b1, 1'b0);
    pulse();
    drain();
    pwr(1'b0, 1'b0);
    pulse();
    drain();
    $display("test power done");
    wrap_up();
  end
endmodule
`default_nettype wire
